/* logic/its_sequencer.sv */
// interrupt and trap sequencer with register bus slave
//
// Summary of operation
// - serve traps, then abort, then nmi, then maskable, trace last.
// - start on nmi falling edge, or maskable level with enable bit set.
// - interrupts begin at instruction boundary or interruptible string point.
// - unfinished string: clear pending bit, return to its first byte.
// - interrupts copy status, then clear stack, user, trace, pending, enable.
// - nmi reads discard byte at ffff00 status 0100, vector 1.
// - non-vectored maskable reads discard byte at ffff00, vector 0.
// - vectored reads byte at fffe00; non-negative byte is vector.
// - bytes -16..-1 fetch cascade address, then read vector status 0101.
// - more negative acknowledge bytes are reserved; the code takes them as plain vectors.
// - push saved status as 16 bits, then run service.
// - read descriptor at vector times four plus table base.
// - load module, read static base, pc from module+8 plus offset.
// - flush queue, push module 16 bits, return address 32 bits.
// - non-trace traps restore stack pointer and status first.
// - trap vectors slave 3, illegal 4, svc 5, ... undefined 10.
// - traps clear stack, user, pending, trace; keep enable; return first byte.
// - trace clears pending, saves, clears stack, user, trace, vector 9.
// - abort restores sp, clears pending and enable too, vector 2.
// - disabled coprocessor instruction raises undefined trap, no bus talk.
// - coprocessor quit bit set takes slave trap at once.
// - trace enable copied to pending at start; pending at end traps.
// - configuration bit selects non-vectored (0) or vectored (1) mode.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module its_sequencer
  import its_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // request pins, active low
  input wire logic nmi_n,
  input wire logic int_n,
  // execution core
  input wire logic inst_start,
  input wire logic inst_end,
  input wire logic boundary,
  input wire logic string_incomplete,
  input wire logic [23:0] cur_inst_addr,
  input wire logic [23:0] next_inst_addr,
  input wire logic [NTRAP-1:0] trap_req,
  input wire logic abort_req,
  input wire logic cop_instr,
  input wire logic [2:0] cop_sel,
  input wire logic cop_status_valid,
  input wire logic [31:0] cop_status,
  output logic cop_go,
  output logic sp_restore,
  output logic queue_flush,
  output logic pc_load,
  output logic [23:0] new_pc,
  output logic seq_busy,
  output logic [15:0] processor_status_word,
  // processor bus master
  output logic pb_req,
  output logic [23:0] pb_addr,
  output logic [3:0] pb_status,
  output logic [1:0] pb_size,
  output logic pb_write,
  output logic [31:0] pb_wdata,
  input wire logic [31:0] pb_rdata,
  input wire logic pb_done,
  input wire logic pb_abort
);

  its_state_e state_reg;
  its_kind_e kind_reg;
  logic [31:0] dispatch_table_base;
  logic [3:0] cfg_reg;
  logic [31:0] isp_reg;
  logic [15:0] psw_start_reg;
  logic [15:0] psw_tmp_reg;
  logic [15:0] module_register;
  logic [31:0] static_base_register;
  logic [15:0] desc_off_reg;
  logic [23:0] ret_addr_reg;
  logic [7:0] vec_reg;
  logic [31:0] casc_reg;
  logic [NTRAP-1:0] trap_pend_reg;
  logic abort_pend_reg;
  logic nmi_pend_reg;
  logic trc_pend_reg;
  logic nmi_s1, nmi_s2, nmi_s3, int_s1, int_s2;
  logic [NTRAP-1:0] trap_set;
  logic [NTRAP-1:0] trap_pick;
  logic [7:0] trap_vec;
  logic take_trap, take_abort, take_nmi, take_int, take_trc, idle;
  logic bus_abort, wr_pend, ah_fire;
  logic [7:0] wr_addr;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; edge detect reads only settled stages
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      nmi_s1 <= 1'b1;
      nmi_s2 <= 1'b1;
      nmi_s3 <= 1'b1;
      int_s1 <= 1'b1;
      int_s2 <= 1'b1;
    end else begin
      nmi_s1 <= nmi_n;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
      int_s1 <= int_n;
      int_s2 <= int_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request selection
  assign idle = (state_reg == S_IDLE);
  assign bus_abort = pb_req & pb_abort;
  // no bus talk for a disabled coprocessor; quit aborts the protocol
  assign cop_go = cop_instr & cfg_reg[CFG_COP0 + 32'(cop_sel[1:0])];

  always_comb begin
    trap_pick = '0;
    trap_vec = TRAP_VEC[0];
    for (int i = NTRAP - 1; i >= 0; i--) begin
      if (trap_pend_reg[i]) begin
        trap_pick = '0;
        trap_pick[i] = 1'b1;
        trap_vec = TRAP_VEC[i];
      end
    end
  end

  // traps and abort come from the instruction itself, so no boundary wait
  assign take_trap = idle & (|trap_pend_reg);
  assign take_abort = idle & ~take_trap & abort_pend_reg;
  assign take_nmi = idle & boundary & ~(|trap_pend_reg) & ~abort_pend_reg
    & nmi_pend_reg;
  assign take_int = idle & boundary & ~(|trap_pend_reg) & ~abort_pend_reg
    & ~nmi_pend_reg & ~int_s2 & processor_status_word[PSW_I];
  assign take_trc = idle & boundary & ~(|trap_pend_reg) & ~abort_pend_reg
    & ~nmi_pend_reg & ~(~int_s2 & processor_status_word[PSW_I])
    & trc_pend_reg;

  generate
    for (genvar g = 0; g < NTRAP; g++) begin : g_trap
      if (g == TR_SLAVE) begin : g_s
        assign trap_set[g] = trap_req[g]
          | (cop_status_valid & cop_status[0]);
      end else if (g == TR_UND) begin : g_u
        assign trap_set[g] = trap_req[g] | (cop_instr & ~cop_go);
      end else begin : g_o
        assign trap_set[g] = trap_req[g];
      end
      // a new request wins over the clear of the same cycle
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          trap_pend_reg[g] <= 1'b0;
        end else begin
          trap_pend_reg[g] <= (trap_pend_reg[g] & ~(take_trap & trap_pick[g]))
            | trap_set[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      abort_pend_reg <= 1'b0;
      nmi_pend_reg <= 1'b0;
      trc_pend_reg <= 1'b0;
    end else begin
      abort_pend_reg <= (abort_pend_reg & ~take_abort) | abort_req
        | bus_abort;
      nmi_pend_reg <= (nmi_pend_reg & ~take_nmi)
        | (nmi_s3 & ~nmi_s2);
      trc_pend_reg <= (trc_pend_reg & ~take_trc)
        | (inst_end & processor_status_word[PSW_P]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status word: sequencer first, then trace copy, then software
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      processor_status_word <= PSW_RST;
      psw_tmp_reg <= PSW_RST;
      psw_start_reg <= PSW_RST;
    end else begin
      if (inst_start) begin
        psw_start_reg <= processor_status_word;
      end
      if (take_trap) begin
        psw_tmp_reg <= psw_start_reg;
        processor_status_word <= psw_start_reg & ~(16'(1) << PSW_S)
          & ~(16'(1) << PSW_U) & ~(16'(1) << PSW_P)
          & ~(16'(1) << PSW_T);
      end else if (take_abort || take_trc) begin
        psw_tmp_reg <= processor_status_word & ~(16'(1) << PSW_P);
        processor_status_word <= processor_status_word & ~(16'(1) << PSW_S)
          & ~(16'(1) << PSW_U) & ~(16'(1) << PSW_T) & ~(16'(1) << PSW_P)
          & ~(16'(take_abort) << PSW_I);
      end else if (take_nmi || take_int) begin
        psw_tmp_reg <= processor_status_word
          & ~(16'(string_incomplete) << PSW_P);
        processor_status_word <= processor_status_word & ~(16'(1) << PSW_S)
          & ~(16'(1) << PSW_U) & ~(16'(1) << PSW_T) & ~(16'(1) << PSW_P)
          & ~(16'(1) << PSW_I);
      end else if (inst_start) begin
        processor_status_word[PSW_P] <=
          processor_status_word[PSW_T];
      end else if (wr_pend && wr_addr == REG_PSW) begin
        processor_status_word <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence state machine
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      kind_reg <= K_TRAP;
      vec_reg <= 8'h00;
      ret_addr_reg <= 24'h000000;
      casc_reg <= 32'h0000_0000;
      module_register <= 16'h0000;
      static_base_register <= 32'h0000_0000;
      desc_off_reg <= 16'h0000;
      new_pc <= 24'h000000;
      isp_reg <= ISP_RST;
    end else begin
      if (wr_pend && wr_addr == REG_ISP) begin
        isp_reg <= hwdata;
      end
      case (state_reg)
        S_IDLE: begin
          if (take_trap) begin
            kind_reg <= K_TRAP;
            vec_reg <= trap_vec;
            ret_addr_reg <= cur_inst_addr;
            state_reg <= S_PPSW;
          end else if (take_abort) begin
            kind_reg <= K_ABORT;
            vec_reg <= VEC_ABORT;
            ret_addr_reg <= cur_inst_addr;
            state_reg <= S_PPSW;
          end else if (take_nmi || take_int) begin
            kind_reg <= take_nmi ? K_NMI : K_INT;
            ret_addr_reg <= string_incomplete ? cur_inst_addr
              : next_inst_addr;
            state_reg <= S_ACK;
          end else if (take_trc) begin
            kind_reg <= K_TRACE;
            vec_reg <= VEC_TRACE;
            ret_addr_reg <= next_inst_addr;
            state_reg <= S_PPSW;
          end
        end
        S_ACK: begin
          if (pb_done) begin
            if (kind_reg == K_NMI) begin
              vec_reg <= VEC_NMI;
              state_reg <= S_PPSW;
            end else if (!cfg_reg[CFG_VEC]) begin
              vec_reg <= VEC_NONVEC;
              state_reg <= S_PPSW;
            end else if (pb_rdata[7:0] >= CASC_LOW) begin
              vec_reg <= pb_rdata[7:0];
              state_reg <= S_CADDR;
            end else begin
              // reserved negatives are taken as plain vectors
              vec_reg <= pb_rdata[7:0];
              state_reg <= S_PPSW;
            end
          end
        end
        S_CADDR: begin
          if (pb_done) begin
            casc_reg <= pb_rdata;
            state_reg <= S_CVEC;
          end
        end
        S_CVEC: begin
          if (pb_done) begin
            vec_reg <= pb_rdata[7:0];
            state_reg <= S_PPSW;
          end
        end
        S_PPSW: begin
          if (pb_done) begin
            isp_reg <= isp_reg - 32'd2;
            state_reg <= S_DESC;
          end
        end
        S_DESC: begin
          if (pb_done) begin
            module_register <= pb_rdata[15:0];
            desc_off_reg <= pb_rdata[31:16];
            state_reg <= S_SB;
          end
        end
        S_SB: begin
          if (pb_done) begin
            static_base_register <= pb_rdata;
            state_reg <= S_PB;
          end
        end
        S_PB: begin
          if (pb_done) begin
            new_pc <= pb_rdata[23:0] + 24'(desc_off_reg);
            state_reg <= S_FLUSH;
          end
        end
        S_FLUSH: begin
          state_reg <= S_PMOD;
        end
        S_PMOD: begin
          if (pb_done) begin
            isp_reg <= isp_reg - 32'd2;
            state_reg <= S_PRET;
          end
        end
        S_PRET: begin
          if (pb_done) begin
            isp_reg <= isp_reg - 32'd4;
            state_reg <= S_IDLE;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
      // an aborted bus cycle drops the sequence; abort is then served
      if (bus_abort) begin
        state_reg <= S_IDLE;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sp_restore <= 1'b0;
    end else begin
      sp_restore <= take_trap | take_abort;
    end
  end

  assign queue_flush = (state_reg == S_FLUSH);
  assign pc_load = (state_reg == S_FLUSH);
  assign seq_busy = ~idle;

  ////////////////////////////////////////////////////////////////////////
  // processor bus cycle request for the current step
  always_comb begin
    pb_req = 1'b1;
    pb_addr = 24'h000000;
    pb_status = ST_DATA;
    pb_size = SZ_DWORD;
    pb_write = 1'b0;
    pb_wdata = 32'h0000_0000;
    case (state_reg)
      S_ACK: begin
        pb_addr = (kind_reg == K_INT && cfg_reg[CFG_VEC]) ? ACK_VEC_ADDR
          : ACK_NONVEC_ADDR;
        pb_status = ST_ACK_MASTER;
        pb_size = SZ_BYTE;
      end
      S_CADDR: begin
        pb_addr = 24'(dispatch_table_base + {{22{vec_reg[7]}}, vec_reg,
          2'b00});
      end
      S_CVEC: begin
        pb_addr = casc_reg[23:0];
        pb_status = ST_ACK_CASC;
        pb_size = SZ_BYTE;
      end
      S_PPSW: begin
        pb_addr = 24'(isp_reg - 32'd2);
        pb_size = SZ_WORD;
        pb_write = 1'b1;
        pb_wdata = {16'h0000, psw_tmp_reg};
      end
      S_DESC: begin
        pb_addr = 24'(dispatch_table_base + {22'h000000, vec_reg,
          2'b00});
      end
      S_SB: begin
        pb_addr = {8'h00, module_register};
      end
      S_PB: begin
        pb_addr = {8'h00, module_register} + PB_OFFSET;
      end
      S_PMOD: begin
        pb_addr = 24'(isp_reg - 32'd2);
        pb_size = SZ_WORD;
        pb_write = 1'b1;
        pb_wdata = {16'h0000, module_register};
      end
      S_PRET: begin
        pb_addr = 24'(isp_reg - 32'd4);
        pb_write = 1'b1;
        pb_wdata = {8'h00, ret_addr_reg};
      end
      default: begin
        pb_req = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // register bus slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ah_fire = hsel & htrans[1] & hready;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= ah_fire & hwrite & (haddr[31:8] == 24'h000000);
      wr_addr <= haddr[7:0];
      if (ah_fire && !hwrite) begin
        if (haddr[31:8] != 24'h000000) begin
          hrdata <= 32'h0000_0000;
        end else if (haddr[7:0] == REG_DTB) begin
          hrdata <= dispatch_table_base;
        end else if (haddr[7:0] == REG_PSW) begin
          hrdata <= {16'h0000, processor_status_word};
        end else if (haddr[7:0] == REG_CFG) begin
          hrdata <= {28'h0000000, cfg_reg};
        end else if (haddr[7:0] == REG_ISP) begin
          hrdata <= isp_reg;
        end else if (haddr[7:0] == REG_MOD) begin
          hrdata <= {16'h0000, module_register};
        end else if (haddr[7:0] == REG_SB) begin
          hrdata <= static_base_register;
        end else if (haddr[7:0] == REG_PC) begin
          hrdata <= {8'h00, new_pc};
        end else if (haddr[7:0] == REG_STAT) begin
          hrdata <= {19'h00000, nmi_pend_reg, abort_pend_reg, seq_busy,
            ~idle & ~pb_req, 1'b0, vec_reg};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dispatch_table_base <= DTB_RST;
      cfg_reg <= CFG_RST;
    end else if (wr_pend) begin
      if (wr_addr == REG_DTB) begin
        dispatch_table_base <= hwdata;
      end else if (wr_addr == REG_CFG) begin
        cfg_reg <= hwdata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_prio_trap_first: assert property (@(posedge mclk) disable iff (rst)
    idle && (|trap_pend_reg) && abort_pend_reg |=> kind_reg == K_TRAP
    && abort_pend_reg) else $error("abort taken before trap");
  a_nmi_ack_cycle: assert property (@(posedge mclk) disable iff (rst)
    state_reg == S_ACK && kind_reg == K_NMI |-> pb_addr == 24'hffff00
    && pb_status == 4'h4 && pb_size == SZ_BYTE)
    else $error("bad nmi acknowledge");
  a_nmi_vector_one: assert property (@(posedge mclk) disable iff (rst)
    state_reg == S_ACK && kind_reg == K_NMI && pb_done && !pb_abort
    |=> vec_reg == 8'h01 && state_reg == S_PPSW)
    else $error("nmi vector not one");
  a_int_clears_bits: assert property (@(posedge mclk) disable iff (rst)
    take_int |=> !processor_status_word[PSW_I] && !processor_status_word[PSW_S]
    && !processor_status_word[PSW_T] && psw_tmp_reg[PSW_I])
    else $error("interrupt status clear wrong");
  a_trap_keeps_ie: assert property (@(posedge mclk) disable iff (rst)
    take_trap |=> processor_status_word[PSW_I] == $past(psw_start_reg[PSW_I])
    && sp_restore) else $error("trap changed enable");
  a_desc_address: assert property (@(posedge mclk) disable iff (rst)
    state_reg == S_DESC |-> pb_addr == 24'(dispatch_table_base
    + 32'(vec_reg) * 4)) else $error("descriptor address wrong");
  a_trace_copy: assert property (@(posedge mclk) disable iff (rst)
    inst_start && !take_trap && !take_abort && !take_nmi && !take_int
    && !take_trc |=> processor_status_word[PSW_P]
    == $past(processor_status_word[PSW_T])) else $error("trace copy");
  a_cop_undefined: assert property (@(posedge mclk) disable iff (rst)
    cop_instr && !cop_go |=> trap_pend_reg[TR_UND] || kind_reg == K_TRAP)
    else $error("disabled coprocessor not trapped");
  a_quit_slave: assert property (@(posedge mclk) disable iff (rst)
    cop_status_valid && cop_status[0] |=> trap_pend_reg[TR_SLAVE]
    || vec_reg == 8'h03) else $error("quit not trapped");
  a_psw_push_word: assert property (@(posedge mclk) disable iff (rst)
    state_reg == S_PPSW |-> pb_write && pb_size == SZ_WORD
    && pb_wdata[15:0] == psw_tmp_reg) else $error("status push wrong");
  a_flush_then_push: assert property (@(posedge mclk) disable iff (rst)
    queue_flush |=> state_reg == S_PMOD ##0 pb_wdata[15:0] == module_register)
    else $error("flush order wrong");

endmodule
`default_nettype wire

/* pkg/its_pkg.sv */
// constants for the interrupt and trap sequencer
package its_pkg;
  // register byte offsets on the register bus
  localparam logic [7:0] REG_DTB = 8'h00;
  localparam logic [7:0] REG_PSW = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_ISP = 8'h0c;
  localparam logic [7:0] REG_MOD = 8'h10;
  localparam logic [7:0] REG_SB = 8'h14;
  localparam logic [7:0] REG_PC = 8'h18;
  localparam logic [7:0] REG_STAT = 8'h1c;
  // reset values
  localparam logic [31:0] DTB_RST = 32'h0000_0000;
  localparam logic [15:0] PSW_RST = 16'h0000;
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [31:0] ISP_RST = 32'h0000_0000;
  // status word bit positions
  localparam int PSW_T = 1;
  localparam int PSW_U = 8;
  localparam int PSW_S = 9;
  localparam int PSW_P = 10;
  localparam int PSW_I = 11;
  // configuration bit positions
  localparam int CFG_VEC = 0;
  localparam int CFG_COP0 = 1;
  // processor bus status codes
  localparam logic [3:0] ST_ACK_MASTER = 4'h4;
  localparam logic [3:0] ST_ACK_CASC = 4'h5;
  localparam logic [3:0] ST_DATA = 4'ha;
  // acknowledge addresses, then program base offset in module
  localparam logic [23:0] ACK_NONVEC_ADDR = 24'hffff00;
  localparam logic [23:0] ACK_VEC_ADDR = 24'hfffe00;
  localparam logic [23:0] PB_OFFSET = 24'h000008;
  // transfer sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_DWORD = 2'h2;
  // vectors
  localparam logic [7:0] VEC_NMI = 8'h01;
  localparam logic [7:0] VEC_NONVEC = 8'h00;
  localparam logic [7:0] VEC_ABORT = 8'h02;
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] CASC_LOW = 8'hf0;
  // trap request index: slave, illegal, svc, div0, flag, bpt, undefined
  localparam int NTRAP = 7;
  localparam int TR_SLAVE = 0;
  localparam int TR_UND = 6;
  localparam logic [7:0] TRAP_VEC [NTRAP] = '{8'h03, 8'h04, 8'h05,
    8'h06, 8'h07, 8'h08, 8'h0a};
  typedef enum {K_TRAP, K_ABORT, K_NMI, K_INT, K_TRACE} its_kind_e;
  typedef enum {S_IDLE, S_ACK, S_CADDR, S_CVEC, S_PPSW, S_DESC, S_SB,
    S_PB, S_FLUSH, S_PMOD, S_PRET} its_state_e;
endpackage

/* sim/its_mem_model.sv */
// memory and interrupt controller model on the processor bus
`timescale 1ns/1ps
`default_nettype none
module its_mem_model
  import its_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // processor bus
  input wire logic pb_req,
  input wire logic [23:0] pb_addr,
  output logic [31:0] pb_rdata,
  output logic pb_done,
  // controller byte and wait states
  input wire logic [7:0] ack_byte,
  input wire logic [3:0] wait_cyc
);
  logic [3:0] cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      pb_done <= 1'b0;
      pb_rdata <= 32'h0;
    end else begin
      pb_done <= 1'b0;
      // released bus never keeps the last value
      pb_rdata <= ~pb_rdata;
      if (pb_req && !pb_done) begin
        if (cnt == wait_cyc) begin
          cnt <= 4'h0;
          pb_done <= 1'b1;
          if (pb_addr == ACK_VEC_ADDR) begin
            pb_rdata <= {24'h0, ack_byte};
          end else begin
            pb_rdata <= {pb_addr[15:0], pb_addr[15:0]};
          end
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the interrupt and trap sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import its_pkg::*;
  logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp, nmi_n, int_n;
  logic inst_start, inst_end, boundary, string_incomplete, abort_req;
  logic cop_instr, cop_status_valid, cop_go, sp_restore, queue_flush;
  logic pc_load, seq_busy, pb_req, pb_write, pb_done, pb_abort;
  logic [31:0] haddr, hwdata, hrdata, cop_status, pb_wdata, pb_rdata, r;
  logic [1:0] htrans, pb_size;
  logic [2:0] hsize, cop_sel;
  logic [23:0] cur_inst_addr, next_inst_addr, new_pc, pb_addr, dtb, isp, pc;
  logic [6:0] trap_req;
  logic [15:0] processor_status_word;
  logic [3:0] pb_status, slow;
  logic [7:0] ack_byte;
  logic [62:0] q[$], e[$];
  int n_mismatch, check_count;
  assign hready = hreadyout;
  its_sequencer dut (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .nmi_n, .int_n,
    .inst_start, .inst_end, .boundary, .string_incomplete, .cur_inst_addr,
    .next_inst_addr, .trap_req, .abort_req, .cop_instr, .cop_sel,
    .cop_status_valid, .cop_status, .cop_go, .sp_restore, .queue_flush,
    .pc_load, .new_pc, .seq_busy, .processor_status_word, .pb_req, .pb_addr,
    .pb_status, .pb_size, .pb_write, .pb_wdata, .pb_rdata, .pb_done,
    .pb_abort);
  its_mem_model mem (.mclk, .rst, .pb_req, .pb_addr, .pb_rdata, .pb_done,
    .ack_byte, .wait_cyc(slow));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // only the low bytes of a push carry meaning
  always @(posedge mclk) begin
    if (pb_req && pb_done) begin
      q.push_back({pb_write, pb_size, pb_status, pb_addr, !pb_write ? 32'h0 :
        pb_size == SZ_WORD ? {16'h0, pb_wdata[15:0]} : {8'h0, pb_wdata[23:0]}});
    end
  end
  ///////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [63:0] g, input logic [63:0] x);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task hw();
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hw();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    hw();
    r = hrdata;
  endtask
  task ex(input logic w, input logic [1:0] z, input logic [3:0] s,
    input logic [23:0] a);
    e.push_back({w, z, s, a, 32'h0});
  endtask
  task serv(input logic [7:0] v, input logic [15:0] pp, input logic [23:0] rt);
    logic [23:0] da, ma;
    da = dtb + {14'h0, v, 2'b00};
    ma = {8'h0, da[15:0]};
    e.push_back({1'b1, SZ_WORD, ST_DATA, isp - 24'h2, 16'h0, pp});
    ex(1'b0, SZ_DWORD, ST_DATA, da);
    ex(1'b0, SZ_DWORD, ST_DATA, ma);
    ex(1'b0, SZ_DWORD, ST_DATA, ma + 24'h8);
    e.push_back({1'b1, SZ_WORD, ST_DATA, isp - 24'h4, 16'h0, ma[15:0]});
    e.push_back({1'b1, SZ_DWORD, ST_DATA, isp - 24'h8, 8'h0, rt});
    isp = isp - 24'h8;
    pc = {ma[7:0] + 8'h08, ma[15:0] + 16'h8} + {8'h0, da[15:0]};
  endtask
  task go(input logic [15:0] px);
    int i;
    for (i = 0; i < 600 && !(q.size() >= e.size() && seq_busy === 1'b0); i++)
      @(posedge mclk);
    if (i == 600) begin
      n_mismatch++;
      summarize();
    end
    foreach (e[k]) chk("pb cycle", q[k], e[k]);
    chk("cycle count", q.size(), e.size());
    chk("new pc", new_pc, pc);
    chk("psw", processor_status_word, px);
    q.delete();
    e.delete();
  endtask
  task istart();
    inst_start <= 1'b1;
    @(posedge mclk);
    inst_start <= 1'b0;
  endtask
  ///////////////////////////////////////////////////////////////////////////
  task s_regs();
    xfer(1'b0, REG_PSW, 32'h0, r);
    chk("psw rst", r, {16'h0, PSW_RST});
    xfer(1'b0, REG_CFG, 32'h0, r);
    chk("cfg rst", r, {28'h0, CFG_RST});
    xfer(1'b1, REG_DTB, {8'h0, dtb}, r);
    xfer(1'b1, REG_ISP, {8'h0, isp}, r);
    xfer(1'b0, REG_DTB, 32'h0, r);
    chk("dtb", r, {8'h0, dtb});
    xfer(1'b0, 8'h40, 32'h0, r);
    chk("unmapped", r, 32'h0);
  endtask
  task s_nmi();
    xfer(1'b1, REG_PSW, 32'h0f02, r);
    string_incomplete <= 1'b1;
    nmi_n <= 1'b0;
    boundary <= 1'b0;
    repeat (8) @(posedge mclk);
    chk("nmi waits for boundary", seq_busy, 1'b0);
    boundary <= 1'b1;
    ex(1'b0, SZ_BYTE, ST_ACK_MASTER, ACK_NONVEC_ADDR);
    serv(VEC_NMI, 16'h0b02, cur_inst_addr);
    go(16'h0000);
    string_incomplete <= 1'b0;
    nmi_n <= 1'b1;
  endtask
  task s_int();
    slow <= 4'h3;
    next_inst_addr <= 24'h00b020;
    xfer(1'b1, REG_PSW, 32'h0800, r);
    int_n <= 1'b0;
    ex(1'b0, SZ_BYTE, ST_ACK_MASTER, ACK_NONVEC_ADDR);
    serv(VEC_NONVEC, 16'h0800, 24'h00b020);
    go(16'h0000);
    xfer(1'b1, REG_CFG, 32'h1, r);
    ack_byte <= 8'hfe;
    xfer(1'b1, REG_PSW, 32'h0800, r);
    ex(1'b0, SZ_BYTE, ST_ACK_MASTER, ACK_VEC_ADDR);
    ex(1'b0, SZ_DWORD, ST_DATA, dtb - 24'h8);
    ex(1'b0, SZ_BYTE, ST_ACK_CASC, 24'hf80ff8);
    serv(8'hf8, 16'h0800, 24'h00b020);
    go(16'h0000);
    ack_byte <= 8'h21;
    xfer(1'b1, REG_PSW, 32'h0800, r);
    ex(1'b0, SZ_BYTE, ST_ACK_MASTER, ACK_VEC_ADDR);
    serv(8'h21, 16'h0800, 24'h00b020);
    go(16'h0000);
    int_n <= 1'b1;
  endtask
  task s_traps();
    for (int t = 0; t < NTRAP; t++) begin
      xfer(1'b1, REG_PSW, 32'h0900, r);
      istart();
      trap_req <= 7'h1 << t;
      abort_req <= (t == NTRAP - 1);
      @(posedge mclk);
      trap_req <= 7'h0;
      abort_req <= 1'b0;
      serv(TRAP_VEC[t], 16'h0900, cur_inst_addr);
      if (t == NTRAP - 1)
        serv(VEC_ABORT, 16'h0800, cur_inst_addr);
      go(t == NTRAP - 1 ? 16'h0000 : 16'h0800);
    end
    slow <= 4'h0;
  endtask
  task s_cop();
    xfer(1'b1, REG_CFG, 32'h0, r);
    xfer(1'b1, REG_PSW, 32'h0800, r);
    istart();
    cop_instr <= 1'b1;
    @(posedge mclk);
    cop_instr <= 1'b0;
    chk("cop go off", cop_go, 1'b0);
    serv(TRAP_VEC[TR_UND], 16'h0800, cur_inst_addr);
    go(16'h0800);
    xfer(1'b1, REG_CFG, 32'h2, r);
    cop_instr <= 1'b1;
    istart();
    cop_instr <= 1'b0;
    chk("cop go on", cop_go, 1'b1);
    cop_status <= 32'h1;
    cop_status_valid <= 1'b1;
    @(posedge mclk);
    cop_status_valid <= 1'b0;
    serv(TRAP_VEC[TR_SLAVE], 16'h0800, cur_inst_addr);
    go(16'h0800);
  endtask
  task s_trace();
    xfer(1'b1, REG_PSW, 32'h0802, r);
    istart();
    inst_end <= 1'b1;
    @(posedge mclk);
    inst_end <= 1'b0;
    serv(VEC_TRACE, 16'h0802, 24'h00b020);
    go(16'h0800);
  endtask
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = 68'h0;
    {inst_start, inst_end, string_incomplete, abort_req} = 4'h0;
    {cop_instr, cop_status_valid, pb_abort} = 3'h0;
    {trap_req, cop_sel, cop_status, ack_byte, slow} = 54'h0;
    {rst, nmi_n, int_n, boundary} = 4'hf;
    hsize = 3'h2;
    cur_inst_addr = 24'h00a010;
    next_inst_addr = 24'h00a014;
    dtb = 24'h001000;
    isp = 24'h002000;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    s_regs();
    s_nmi();
    s_int();
    s_traps();
    s_cop();
    s_trace();
    summarize();
  end
endmodule
`default_nettype wire
